//--- hw/scan_irq_pkg.sv
package scan_irq_pkg;
   // Control/status register field positions
   localparam int CSR_SCAN_ERR    = 15;
   localparam int CSR_PWR_LOSS    = 14;
   localparam int CSR_IM_PEND     = 13;
   localparam int CSR_DEF_PEND    = 12;
   localparam int CSR_IM_DONE     = 7;
   localparam int CSR_DEF_DONE    = 5;
   localparam int CSR_IMMEDIATE_SEARCH_ENABLE  = 4;
   localparam int CSR_DEFERRED_SEARCH_ENABLE = 3;
   localparam int CSR_IM_IRQ_EN   = 2;
   localparam int CSR_DEF_IRQ_EN  = 1;
   localparam int CSR_FLAG_CLR    = 0;
   // Bits software may write; error and done bits excluded
   localparam logic [15:0] CSR_WR_MASK   = 16'h0F1F;
   localparam logic [15:0] CSR_RESET     = 16'h0000;
   localparam logic [15:0] RESULT_RESET  = 16'h0000;
   // Slot value reserved for the status register itself
   localparam logic [7:0]  STATUS_SLOT   = 8'hFF;
   // Scan time limit and its cycle count at 40 MHz
   localparam int SCAN_MAX_NS    = 20000;
   localparam int CLK_PERIOD_NS  = 25;
   localparam int SCAN_MAX_CYC   = SCAN_MAX_NS / CLK_PERIOD_NS;
   // Data word layout of a converter module
   localparam int CONV_CHAN_LSB  = 14;
   localparam int CONV_VAL_LSB   = 4;

   typedef enum logic [1:0] {
      SCAN_IDLE = 2'b00,
      SCAN_IM   = 2'b01,
      SCAN_DEF  = 2'b11
   } scan_state_t;

   // Module bus as seen by the controller
   typedef struct packed {
      logic       im_req;
      logic       def_req;
      logic       stop;
      logic [3:0] type_code;
   } field_bus_t;

   // One programmed access from the processor
   typedef struct packed {
      logic        csr_wr;
      logic        csr_rd;
      logic        result_rd;
      logic        mod_rd;
      logic        mod_wr;
      logic        mod_conv;
      logic [7:0]  mod_slot;
      logic [15:0] wdata;
   } host_acc_t;
endpackage

//--- hw/field_request_scan_interrupt.sv
`timescale 1ns/10ps
// Function
// - Result bits 11..8 show the found module's 4-bit type code.
// - Result bits 7..0 hold found slot; cleared on scan start or init.
// - Digital modules pass 16 bits; converters use upper 12 bits only.
// - Programmed transfers take precedence over the hardware search.
// - Status bits 4,3,2,1 enable immediate/deferred scan and interrupts.
// - Both enables set: search automatically, then raise the bus request.
// - Scan enable only: scan and flag done without any bus request.
// - Interrupt enable only: pending flag readable; faults still raise level 6.
// - Both enables clear: no scan, no request, pending flag still readable.
// - Immediate request starts a scan; immediate beats deferred.
// - Further immediate requests stay posted until serviced.
// - Immediate scan finishes within 20 microseconds.
// - Immediate request aborts a deferred scan and keeps control.
// - Deferred scan finishes within 20 microseconds.
// - Found immediate requests use level 6, deferred use level 4.
// - Power loss or scan error raises level 6, gated by immediate enable.
// - Immediate request during deferred service sets result bit 15.
// - Scan error and power loss share the immediate level and vector.
// - Scan error or power loss forces slot value to all ones.
// - Done bits 7 and 5 set on completion; not writable by software.
// - With flag clear set, module read clears done bit and module flag.
// - Scan error on overflow; blocks scan start; cleared by enable set, flag clear.
// - Deferred-void bit clears on serviced module read with flag clear set.
module field_request_scan_interrupt #(
   parameter int SLOT_COUNT = 255
) (
   // Clock and reset
   input  wire logic                      clk_sys_in,
   input  wire logic                      reset_in,
   // Processor access
   input  wire scan_irq_pkg::host_acc_t   host_in,
   output logic [15:0]                    rdata_out,
   // Module bus
   input  wire scan_irq_pkg::field_bus_t  field_in,
   input  wire logic [15:0]               mod_rdata_in,
   input  wire logic                      expander_power_loss_in,
   output logic [7:0]                     scan_slot_out,
   output logic                           slot_from_scan_out,
   output logic                           flag_reset_out,
   output logic [7:0]                     flag_reset_slot_out,
   output logic [15:0]                    mod_wdata_out,
   output logic                           mod_wr_out,
   // Processor bus requests
   output logic                           bus_req6_out,
   output logic                           bus_req4_out
);
   if (SLOT_COUNT < 1 || SLOT_COUNT > 255) begin : g_chk
      $error("SLOT_COUNT must lie in 1..255");
   end

   localparam logic [7:0] LAST_SLOT = 8'(SLOT_COUNT - 1);

   // Timing notes for users of this block:
   // - scanner steps one slot per idle clock
   // - a full sweep of 255 slots stays well inside the scan time limit
   // - any programmed access freezes the slot for that cycle, except when an immediate request aborts a deferred scan
   // - heavy host traffic therefore stretches a scan
   // - a module flag is reset one cycle after the serviced read
   // - no scan starts while that reset is in flight:
   //   the stale request would restart the scanner
   //   and end in a false overflow
   // - after an overflow the scanner waits until software clears
   //   the error, so the fault stays visible instead of
   //   retriggering on a request that no module answers

   scan_irq_pkg::scan_state_t state_q, state_d;
   logic [15:0] csr_q, csr_d;
   logic [15:0] result_q, result_d;
   logic [7:0]  slot_q, slot_d;
   logic        req6_q, req6_d, req4_q, req4_d;
   logic [15:0] rdata_q, rdata_d;
   logic        frst_q, frst_d;
   logic [7:0]  frst_slot_q, frst_slot_d;
   logic [15:0] mwd_q, mwd_d;
   logic        mwr_q, mwr_d;
   logic        scan_on_q, scan_on_d;
   logic        busy;

   // Converter data keeps the channel and value fields only
   function automatic logic [15:0] conv_mask(input logic [15:0] w);
      conv_mask = {w[15:scan_irq_pkg::CONV_CHAN_LSB],
                   w[scan_irq_pkg::CONV_CHAN_LSB-1:scan_irq_pkg::CONV_VAL_LSB], 4'h0};
   endfunction

   // Any programmed access claims the slot path this cycle
   assign busy = host_in.csr_wr | host_in.csr_rd | host_in.result_rd
               | host_in.mod_rd | host_in.mod_wr;

   // Scanner, status and result next-state
   always_comb begin
      logic flag_clr;
      logic [15:0] wr_val;
      logic [15:0] new_en;
      flag_clr = csr_q[scan_irq_pkg::CSR_FLAG_CLR] & host_in.mod_rd;
      wr_val   = host_in.wdata & scan_irq_pkg::CSR_WR_MASK;
      new_en   = wr_val & ~csr_q;
      state_d  = state_q;
      slot_d   = slot_q;
      result_d = result_q;
      csr_d    = csr_q;
      // Pending flags mirror the bus; readable in every mode
      csr_d[scan_irq_pkg::CSR_IM_PEND]  = field_in.im_req;
      csr_d[scan_irq_pkg::CSR_DEF_PEND] = field_in.def_req;
      if (host_in.csr_wr) begin
         csr_d = (csr_q & ~scan_irq_pkg::CSR_WR_MASK) | wr_val;
         csr_d[scan_irq_pkg::CSR_IM_PEND]  = field_in.im_req;
         csr_d[scan_irq_pkg::CSR_DEF_PEND] = field_in.def_req;
         // Fresh interrupt enables retire old done and error flags
         if (new_en[scan_irq_pkg::CSR_IM_IRQ_EN] | new_en[scan_irq_pkg::CSR_DEF_IRQ_EN]) begin
            csr_d[scan_irq_pkg::CSR_IM_DONE]  = 1'b0;
            csr_d[scan_irq_pkg::CSR_DEF_DONE] = 1'b0;
            csr_d[scan_irq_pkg::CSR_SCAN_ERR] = 1'b0;
         end
         if (wr_val[scan_irq_pkg::CSR_FLAG_CLR]) begin
            csr_d[scan_irq_pkg::CSR_SCAN_ERR] = 1'b0;
         end
      end
      // Serviced read with flag clear retires done and void bits
      if (flag_clr) begin
         csr_d[scan_irq_pkg::CSR_IM_DONE]  = 1'b0;
         csr_d[scan_irq_pkg::CSR_DEF_DONE] = 1'b0;
         result_d[15] = 1'b0;
      end
      // Immediate arrival while deferred result waits voids it
      if (field_in.im_req && (state_q == scan_irq_pkg::SCAN_DEF
          || csr_q[scan_irq_pkg::CSR_DEF_DONE])) begin
         result_d[15] = 1'b1;
      end
      unique case (state_q)
         scan_irq_pkg::SCAN_IDLE: begin
            // Immediate start; held off by pending flag reset or error
            if (field_in.im_req && csr_q[scan_irq_pkg::CSR_IMMEDIATE_SEARCH_ENABLE]
                && !csr_q[scan_irq_pkg::CSR_IM_DONE]
                && !frst_q
                && !csr_q[scan_irq_pkg::CSR_SCAN_ERR]) begin
               state_d = scan_irq_pkg::SCAN_IM;
               slot_d  = 8'h00;
               result_d[7:0] = 8'h00;
               csr_d[scan_irq_pkg::CSR_SCAN_ERR] = 1'b0;
            end else if (field_in.def_req && !field_in.im_req
                && csr_q[scan_irq_pkg::CSR_DEFERRED_SEARCH_ENABLE]
                && !csr_q[scan_irq_pkg::CSR_DEF_DONE]
                && !frst_q
                && !csr_q[scan_irq_pkg::CSR_SCAN_ERR]) begin
               state_d = scan_irq_pkg::SCAN_DEF;
               slot_d  = 8'h00;
               result_d[7:0] = 8'h00;
               csr_d[scan_irq_pkg::CSR_SCAN_ERR] = 1'b0;
            end
         end

         // Scanning: abort, freeze, stop, overflow or step
         scan_irq_pkg::SCAN_IM, scan_irq_pkg::SCAN_DEF: begin
            if (state_q == scan_irq_pkg::SCAN_DEF && field_in.im_req
                && csr_q[scan_irq_pkg::CSR_IMMEDIATE_SEARCH_ENABLE]) begin
               state_d = scan_irq_pkg::SCAN_IM;
               slot_d  = 8'h00;
            end else if (busy) begin
               slot_d = slot_q;
            end else if (field_in.stop) begin
               state_d = scan_irq_pkg::SCAN_IDLE;
               result_d[11:8] = field_in.type_code;
               result_d[7:0]  = slot_q;
               if (state_q == scan_irq_pkg::SCAN_IM) begin
                  csr_d[scan_irq_pkg::CSR_IM_DONE] = 1'b1;
               end else begin
                  csr_d[scan_irq_pkg::CSR_DEF_DONE] = 1'b1;
               end
            end else if (slot_q == LAST_SLOT) begin
               // Overflow without a requester is a logic fault
               state_d = scan_irq_pkg::SCAN_IDLE;
               csr_d[scan_irq_pkg::CSR_SCAN_ERR] = 1'b1;
            end else begin
               slot_d = slot_q + 8'h01;
            end
         end
         default: state_d = scan_irq_pkg::SCAN_IDLE;
      endcase
      // Power loss is sticky until reset
      if (expander_power_loss_in) begin
         csr_d[scan_irq_pkg::CSR_PWR_LOSS] = 1'b1;
      end
      // Faults point software at the status register
      if (csr_d[scan_irq_pkg::CSR_SCAN_ERR] | csr_d[scan_irq_pkg::CSR_PWR_LOSS]) begin
         result_d[7:0] = scan_irq_pkg::STATUS_SLOT;
      end

      // Registered scan indicator keeps the output glitch free
      scan_on_d = (state_d != scan_irq_pkg::SCAN_IDLE);
   end

   // Bus requests follow the done and fault flags one cycle late
   always_comb begin
      req6_d = csr_q[scan_irq_pkg::CSR_IM_IRQ_EN]
             & (csr_q[scan_irq_pkg::CSR_IM_DONE] | csr_q[scan_irq_pkg::CSR_SCAN_ERR]
             | csr_q[scan_irq_pkg::CSR_PWR_LOSS]);
      req4_d = csr_q[scan_irq_pkg::CSR_DEF_IRQ_EN]
             & csr_q[scan_irq_pkg::CSR_DEF_DONE];
   end

   // Request levels; dropped by initialize
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         req6_q <= 1'b0;
         req4_q <= 1'b0;
      end else begin
         req6_q <= req6_d;
         req4_q <= req4_d;
      end
   end

   // Read data and module-side outputs of a programmed access
   always_comb begin
      rdata_d = rdata_q;
      if (host_in.csr_rd) begin
         rdata_d = csr_q;
      end else if (host_in.result_rd) begin
         rdata_d = result_q;
      end else if (host_in.mod_rd) begin
         rdata_d = host_in.mod_conv ? conv_mask(mod_rdata_in) : mod_rdata_in;
      end
      frst_d      = csr_q[scan_irq_pkg::CSR_FLAG_CLR] & host_in.mod_rd;
      frst_slot_d = host_in.mod_slot;
      mwr_d       = host_in.mod_wr;
      mwd_d       = host_in.mod_conv ? conv_mask(host_in.wdata) : host_in.wdata;
   end

   // Host-side registers; read data holds until the next read
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         rdata_q     <= 16'h0000;
         frst_q      <= 1'b0;
         frst_slot_q <= 8'h00;
         mwd_q       <= 16'h0000;
         mwr_q       <= 1'b0;
      end else begin
         rdata_q     <= rdata_d;
         frst_q      <= frst_d;
         frst_slot_q <= frst_slot_d;
         mwd_q       <= mwd_d;
         mwr_q       <= mwr_d;
      end
   end

   // Scanner, status and result registers; initialize clears all
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         state_q     <= scan_irq_pkg::SCAN_IDLE;
         csr_q       <= scan_irq_pkg::CSR_RESET;
         result_q    <= scan_irq_pkg::RESULT_RESET;
         slot_q      <= 8'h00;
         scan_on_q   <= 1'b0;
      end else begin
         state_q     <= state_d;
         csr_q       <= csr_d;
         result_q    <= result_d;
         slot_q      <= slot_d;
         scan_on_q   <= scan_on_d;
      end
   end

   // Slot path follows the scanner; host slot rides on flag_reset_slot_out
   assign scan_slot_out       = slot_q;
   assign slot_from_scan_out  = scan_on_q;
   assign flag_reset_out      = frst_q;
   assign flag_reset_slot_out = frst_slot_q;
   assign mod_wdata_out       = mwd_q;
   assign mod_wr_out          = mwr_q;
   assign bus_req6_out        = req6_q;
   assign bus_req4_out        = req4_q;
   assign rdata_out           = rdata_q;
endmodule

//--- tb/scan_irq_assertions.sv
`timescale 1ns/10ps
module scan_irq_assertions #(
   parameter int SLOT_COUNT = 255
) (
   // Watched ports
   input wire logic                     clk_sys_in,
   input wire logic                     reset_in,
   input wire scan_irq_pkg::host_acc_t  host_in,
   input wire scan_irq_pkg::field_bus_t field_in,
   input wire logic [7:0]               scan_slot_out,
   input wire logic                     slot_from_scan_out,
   input wire logic                     flag_reset_out,
   input wire logic [7:0]               flag_reset_slot_out,
   input wire logic [15:0]              mod_wdata_out,
   input wire logic                     mod_wr_out,
   input wire logic                     bus_req6_out,
   input wire logic                     bus_req4_out
);
   localparam int SCAN_LIM = 800;
   logic idle;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   // No programmed access this cycle
   assign idle = !(host_in.csr_wr || host_in.csr_rd || host_in.result_rd || host_in.mod_rd || host_in.mod_wr);
   sequence s_found; slot_from_scan_out && field_in.stop && idle; endsequence
   sequence s_paused; slot_from_scan_out && !field_in.stop && !idle; endsequence
   property p_conv; host_in.mod_wr && host_in.mod_conv |=> mod_wr_out && mod_wdata_out[3:0] == 4'h0; endproperty
   a_conv: assert property (p_conv) else $error("converter write kept low bits");
   property p_dig; host_in.mod_wr && !host_in.mod_conv |=> mod_wdata_out == $past(host_in.wdata); endproperty
   a_dig: assert property (p_dig) else $error("digital write word altered");
   property p_hold; s_paused |=> scan_slot_out == $past(scan_slot_out); endproperty
   a_hold: assert property (p_hold) else $error("scanner moved during access");
   property p_found; s_found |=> !slot_from_scan_out; endproperty
   a_found: assert property (p_found) else $error("scan ran past requester");
   property p_bound; $rose(slot_from_scan_out) |-> ##[1:SCAN_LIM] !slot_from_scan_out; endproperty
   a_bound: assert property (p_bound) else $error("scan too long");
   property p_start; $rose(slot_from_scan_out) |-> scan_slot_out == 8'h00; endproperty
   a_start: assert property (p_start) else $error("scan did not start at slot zero");
   property p_flag; flag_reset_out |-> $past(host_in.mod_rd) && flag_reset_slot_out == $past(host_in.mod_slot);
   endproperty
   a_flag: assert property (p_flag) else $error("flag reset without module read");
   property p_init; $fell(reset_in) |-> !bus_req6_out && !bus_req4_out && !slot_from_scan_out; endproperty
   a_init: assert property (p_init) else $error("outputs not cleared by initialize");
endmodule
bind field_request_scan_interrupt scan_irq_assertions #(.SLOT_COUNT(SLOT_COUNT)) scan_irq_assertions_i (
   .clk_sys_in, .reset_in, .host_in, .field_in, .scan_slot_out, .slot_from_scan_out, .flag_reset_out,
   .flag_reset_slot_out, .mod_wdata_out, .mod_wr_out, .bus_req6_out, .bus_req4_out);

//--- tb/field_modules_model.sv
`timescale 1ns/10ps
module field_modules_model #(
   parameter logic [3:0] IM_TYPE  = 4'hA, // Arbitrary type code
   parameter logic [3:0] DEF_TYPE = 4'hC  // Arbitrary type code
) (
   // Clock and reset
   input  wire logic                     clk_sys_in,
   input  wire logic                     reset_in,
   // Requests to post
   input  wire logic                     post_im_in,
   input  wire logic                     post_def_in,
   input  wire logic [7:0]               im_slot_in,
   input  wire logic [7:0]               def_slot_in,
   // Controller side
   input  wire logic [7:0]               scan_slot_in,
   input  wire logic                     scanning_in,
   input  wire logic                     flag_reset_in,
   input  wire logic [7:0]               flag_slot_in,
   output scan_irq_pkg::field_bus_t      field_out,
   output logic [15:0]                   mod_rdata_out
);
   logic im_q, def_q, hit_im, hit_def;
   // Flags stay posted until the controller resets them
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         im_q  <= 1'b0;
         def_q <= 1'b0;
      end else begin
         if (post_im_in) im_q <= 1'b1;
         else if (flag_reset_in && flag_slot_in == im_slot_in) im_q <= 1'b0;
         if (post_def_in) def_q <= 1'b1;
         else if (flag_reset_in && flag_slot_in == def_slot_in) def_q <= 1'b0;
      end
   end
   // Unselected type lines wander; stale values match the default IM_TYPE at slot 5 and DEF_TYPE at slot 3
   assign hit_im  = scanning_in && im_q && scan_slot_in == im_slot_in;
   assign hit_def = scanning_in && def_q && !im_q && scan_slot_in == def_slot_in;
   assign field_out = '{im_req: im_q, def_req: def_q, stop: hit_im || hit_def,
                        type_code: hit_im ? IM_TYPE : (hit_def ? DEF_TYPE : ~scan_slot_in[3:0])};
   assign mod_rdata_out = 16'hB6E1;
endmodule

//--- tb/testbench.sv
`timescale 1ns/10ps
module testbench;
   localparam logic [5:0] CW = 6'h20, CR = 6'h10, RR = 6'h08, MR = 6'h04, MW = 6'h02;
   logic clk_sys_in = 1'b0, reset_in = 1'b1, pwr = 1'b0, post_im = 1'b0, post_def = 1'b0;
   scan_irq_pkg::host_acc_t host_in = '0;
   scan_irq_pkg::field_bus_t field_in;
   logic [7:0] im_slot = 8'h00, def_slot = 8'h00, slot, fslot;
   logic [15:0] rdata, mdata, wdata_o, v;
   logic scanning, fres, wr_o, req6, req4;
   int errors = 0, checked = 0;
   logic [15:0] rows [4][2] = '{'{16'hFE1F, 16'h0E1F}, '{16'h00A0, 16'h0000}, '{16'h0006, 16'h0006},
                                '{16'h0000, 16'h0000}};
   always #12.5 clk_sys_in = ~clk_sys_in;
   field_request_scan_interrupt #(.SLOT_COUNT(8)) field_request_scan_interrupt_i (.clk_sys_in, .reset_in,
      .host_in, .rdata_out(rdata), .field_in, .mod_rdata_in(mdata), .expander_power_loss_in(pwr),
      .scan_slot_out(slot), .slot_from_scan_out(scanning), .flag_reset_out(fres), .flag_reset_slot_out(fslot),
      .mod_wdata_out(wdata_o), .mod_wr_out(wr_o), .bus_req6_out(req6), .bus_req4_out(req4));
   field_modules_model field_modules_model_i (.clk_sys_in, .reset_in, .post_im_in(post_im),
      .post_def_in(post_def), .im_slot_in(im_slot), .def_slot_in(def_slot), .scan_slot_in(slot),
      .scanning_in(scanning), .flag_reset_in(fres), .flag_slot_in(fslot), .field_out(field_in),
      .mod_rdata_out(mdata));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One host access; v holds the answered word
   task automatic acc(input logic [5:0] k, input logic [7:0] s, input logic [15:0] d);
      @(posedge clk_sys_in) host_in <= {k, s, d};
      @(posedge clk_sys_in) host_in <= '0;
      @(posedge clk_sys_in) v = rdata;
   endtask
   task automatic post(input logic [1:0] m, input logic [7:0] si, input logic [7:0] sd);
      @(posedge clk_sys_in) {post_im, post_def} <= m;
      im_slot <= si;
      def_slot <= sd;
      @(posedge clk_sys_in) {post_im, post_def} <= 2'b00;
   endtask
   // Bounded wait for a bus request
   task automatic wait_req(input logic [1:0] m);
      for (int n = 0; n < 900 && ({req6, req4} & m) == 2'b00; n++) @(posedge clk_sys_in);
      chk(16'(({req6, req4} & m) != 2'b00), 16'h0001);
   endtask
   task automatic final_report;
      if (errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk_sys_in);
      errors++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge clk_sys_in);
      reset_in <= 1'b0;
      acc(RR, 8'h00, 16'h0000); chk(v, 16'h0000);
      foreach (rows[i]) begin
         acc(CW, 8'h00, rows[i][0]);
         acc(CR, 8'h00, 16'h0000); chk(v, rows[i][1]);
      end
      // Immediate found at level 6, then serviced with flag reset
      acc(CW, 8'h00, 16'h0015); post(2'b10, 8'h05, 8'h00); acc(CR, 8'h00, 16'h0000);
      wait_req(2'b10);
      acc(RR, 8'h00, 16'h0000); chk(v, 16'h0A05);
      acc(CR, 8'h00, 16'h0000); chk(v & 16'h20A0, 16'h2080);
      acc(CW, 8'h00, 16'h0001); acc(MR, 8'h05, 16'h0000); chk(v, 16'hB6E1);
      acc(CR, 8'h00, 16'h0000); chk({v[15:1], req6}, 16'h0000);
      // Deferred scan without interrupt is polled
      acc(CW, 8'h00, 16'h0009); post(2'b01, 8'h00, 8'h03);
      for (int n = 0; n < 30 && v[5] !== 1'b1; n++) acc(CR, 8'h00, 16'h0000);
      chk({v[5], req4}, 16'h0002);
      acc(RR, 8'h00, 16'h0000); chk(v, 16'h0C03);
      acc(CW, 8'h00, 16'h0001); acc(MR, 8'h03, 16'h0000);
      // Both posted: immediate wins, deferred follows at level 4
      acc(CW, 8'h00, 16'h001F); post(2'b11, 8'h06, 8'h02); wait_req(2'b11);
      chk({req6, req4}, 16'h0002);
      acc(RR, 8'h00, 16'h0000); chk(v & 16'h0FFF, 16'h0A06);
      acc(CW, 8'h00, 16'h000B); acc(MR, 8'h06, 16'h0000); wait_req(2'b01);
      acc(RR, 8'h00, 16'h0000); chk(v, 16'h0C02);
      acc(CW, 8'h00, 16'h0001); acc(MR, 8'h02, 16'h0000);
      // No module answers: overflow to scan error
      acc(CW, 8'h00, 16'h0015); post(2'b10, 8'h20, 8'h00); wait_req(2'b10);
      acc(RR, 8'h00, 16'h0000); chk(v & 16'h00FF, 16'h00FF);
      acc(CR, 8'h00, 16'h0000); chk(v & 16'h8000, 16'h8000);
      acc(CW, 8'h00, 16'h0001); acc(MR, 8'h20, 16'h0000);
      acc(CW, 8'h00, 16'h0004); acc(CR, 8'h00, 16'h0000); chk(v, 16'h0004);
      acc(MW | 6'h01, 8'h09, 16'hFFFF); acc(MW, 8'h09, 16'h1234);
      // Power loss with scanning off still raises level 6
      pwr <= 1'b1; wait_req(2'b10);
      acc(CR, 8'h00, 16'h0000); chk(v & 16'hC000, 16'h4000);
      acc(RR, 8'h00, 16'h0000); chk(v & 16'h00FF, 16'h00FF);
      reset_in <= 1'b1;
      repeat (6) @(posedge clk_sys_in);
      pwr <= 1'b0;
      reset_in <= 1'b0;
      acc(CR, 8'h00, 16'h0000); chk({v[15:1], req6}, 16'h0000);
      final_report();
   end
endmodule
